// *** rtl/hcb_boot_seq.sv ***
// Controller reset sequencer, mux event outputs and status port
`timescale 1ns/100ps
// ========================================
module hcb_boot_seq (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic cfg_done_in,
    input wire logic controller_3v3_rail_in,
    input wire logic host_gate_en_in,
    input wire logic host_boot_ok_in,
    input wire logic attach_in,
    input wire logic orient_in,
    input wire logic usb3_evt_in,
    input wire logic dp_evt_in,
    input wire logic hsl_evt_in,
    input wire logic gpio_mux_mode_in,
    input wire logic irq_clear_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic host_ctrl_reset_line_n_out,
    output logic flash_grant_out,
    output logic sideband_pair_select_a_out,
    output logic sideband_pair_select_b_out,
    output logic dp_aux_path_enable_out,
    output logic low_speed_path_enable_out,
    output logic ss_flip_out,
    output logic usb3_lane_control_out,
    output logic dp_lane_control_out,
    output logic host_irq_n_out,
    output logic sda_oe_out
);
    import hcb_pkg::*;
    hcb_state_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [1:0] rail_sync_reg;
    logic rstn_line_reg, grant_reg, irq_n_reg, attach_d_reg;
    logic sa_reg, sb_reg, aux_en_reg, ls_en_reg, flip_reg, usb3_lane_reg, dp_lane_reg;
    logic read_done;
    logic [7:0] status_byte;
    wire rail_ok = rail_sync_reg[1];
    wire settle_done = (cnt_reg == CNT_W'(RAIL_SETTLE_CYC - 1));
    wire host_ok = !host_gate_en_in || host_boot_ok_in;
    wire attach_chg = attach_in ^ attach_d_reg;
    wire release_now = (state_next == HCB_ST_RUN);

    // ========================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HCB_ST_CFG_LOAD: if (cfg_done_in) state_next = HCB_ST_WAIT_RAIL;
            HCB_ST_WAIT_RAIL: if (rail_ok) state_next = HCB_ST_SETTLE;
            HCB_ST_SETTLE: begin
                if (!rail_ok) state_next = HCB_ST_WAIT_RAIL;
                else if (settle_done) state_next = HCB_ST_WAIT_HOST;
            end
            HCB_ST_WAIT_HOST: begin
                if (!rail_ok) state_next = HCB_ST_WAIT_RAIL;
                else if (host_ok) state_next = HCB_ST_RUN;
            end
            HCB_ST_RUN: if (!rail_ok) state_next = HCB_ST_WAIT_RAIL;
            default: state_next = HCB_ST_CFG_LOAD;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state_reg <= HCB_ST_CFG_LOAD;
            cnt_reg <= '0;
            rail_sync_reg <= 2'b00;
            rstn_line_reg <= 1'b0;
            grant_reg <= 1'b0;
        end else if (ce_in) begin
            rail_sync_reg <= {rail_sync_reg[0], controller_3v3_rail_in};
            state_reg <= state_next;
            cnt_reg <= (state_reg == HCB_ST_SETTLE && state_next == HCB_ST_SETTLE) ?
                cnt_reg + CNT_W'(1) : '0;
            // Dedicated reset line, released only in RUN
            rstn_line_reg <= release_now;
            // Flash handed over only after configuration load
            if (state_reg != HCB_ST_CFG_LOAD) grant_reg <= 1'b1;
        end
    end

    // ========================================
    // Mux event outputs
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sa_reg <= 1'b0;
            sb_reg <= 1'b0;
            aux_en_reg <= 1'b0;
            ls_en_reg <= 1'b0;
            flip_reg <= 1'b0;
            usb3_lane_reg <= 1'b0;
            dp_lane_reg <= 1'b0;
        end else if (ce_in) begin
            sa_reg <= orient_in;
            sb_reg <= orient_in;
            aux_en_reg <= dp_evt_in;
            ls_en_reg <= hsl_evt_in;
            flip_reg <= gpio_mux_mode_in & orient_in;
            usb3_lane_reg <= gpio_mux_mode_in & usb3_evt_in;
            dp_lane_reg <= gpio_mux_mode_in & dp_evt_in;
        end
    end

    // ========================================
    // Interrupt to controller; set beats clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_n_reg <= 1'b1;
            attach_d_reg <= 1'b0;
        end else if (ce_in) begin
            attach_d_reg <= attach_in;
            if (attach_chg) irq_n_reg <= 1'b0;
            else if (irq_clear_in || read_done) irq_n_reg <= 1'b1;
        end
    end

    assign status_byte = {2'b00, state_reg == HCB_ST_RUN, attach_in & hsl_evt_in,
        attach_in & dp_evt_in, attach_in & usb3_evt_in, attach_in & orient_in,
        attach_in};

    hcb_i2c_target u_target (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .status_in(status_byte),
        .sda_oe_out(sda_oe_out),
        .read_done_out(read_done)
    );

    assign host_ctrl_reset_line_n_out = rstn_line_reg;
    assign flash_grant_out = grant_reg;
    assign sideband_pair_select_a_out = sa_reg;
    assign sideband_pair_select_b_out = sb_reg;
    assign dp_aux_path_enable_out = aux_en_reg;
    assign low_speed_path_enable_out = ls_en_reg;
    assign ss_flip_out = flip_reg;
    assign usb3_lane_control_out = usb3_lane_reg;
    assign dp_lane_control_out = dp_lane_reg;
    assign host_irq_n_out = irq_n_reg;

    // ========================================
    // Assertions
    logic [15:0] chk_rail_cnt;
    always_ff @(posedge clk_in) begin
        if (!rstn_in || !rail_ok) chk_rail_cnt <= '0;
        else if (ce_in && chk_rail_cnt != 16'hffff) chk_rail_cnt <= chk_rail_cnt + 16'h1;
    end
    property p_hold_cfg;
        @(posedge clk_in) disable iff (!rstn_in)
        (state_reg == HCB_ST_CFG_LOAD) |-> !host_ctrl_reset_line_n_out;
    endproperty
    a_hold_cfg: assert property (p_hold_cfg) else $error("reset released during load");
    property p_settle;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(host_ctrl_reset_line_n_out) |-> chk_rail_cnt >= 16'(RAIL_SETTLE_CYC);
    endproperty
    a_settle: assert property (p_settle) else $error("reset released too early");
    property p_grant;
        @(posedge clk_in) disable iff (!rstn_in)
        flash_grant_out |-> state_reg != HCB_ST_CFG_LOAD;
    endproperty
    a_grant: assert property (p_grant) else $error("flash granted before load");
    property p_host;
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(host_ctrl_reset_line_n_out) |-> $past(host_ok);
    endproperty
    a_host: assert property (p_host) else $error("released before host boot");
    property p_sb;
        @(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> sideband_pair_select_a_out == $past(orient_in)
            && dp_aux_path_enable_out == $past(dp_evt_in);
    endproperty
    a_sb: assert property (p_sb) else $error("sideband mux mismatch");
    property p_ss;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && !gpio_mux_mode_in) |=> !usb3_lane_control_out && !dp_lane_control_out;
    endproperty
    a_ss: assert property (p_ss) else $error("lane mux driven outside gpio mode");
    property p_irq;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && attach_chg) |=> !host_irq_n_out;
    endproperty
    a_irq: assert property (p_irq) else $error("missing connection interrupt");
    property p_rail_drop;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && !rail_ok) |=> !host_ctrl_reset_line_n_out;
    endproperty
    a_rail_drop: assert property (p_rail_drop) else $error("reset out with rail low");
    property p_sb_pair;
        @(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> sideband_pair_select_b_out == $past(orient_in)
            && low_speed_path_enable_out == $past(hsl_evt_in);
    endproperty
    a_sb_pair: assert property (p_sb_pair) else $error("sideband b mismatch");
    property p_ss_on;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && gpio_mux_mode_in) |=> ss_flip_out == $past(orient_in)
            && usb3_lane_control_out == $past(usb3_evt_in)
            && dp_lane_control_out == $past(dp_evt_in);
    endproperty
    a_ss_on: assert property (p_ss_on) else $error("lane mux not following events");
    property p_read_clr;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && read_done && !attach_chg) |=> host_irq_n_out;
    endproperty
    a_read_clr: assert property (p_read_clr) else $error("status read left irq set");
    c_release: cover property (@(posedge clk_in) $rose(host_ctrl_reset_line_n_out));
    c_irq: cover property (@(posedge clk_in) $fell(host_irq_n_out));
    c_read: cover property (@(posedge clk_in) read_done);
    c_gate_wait: cover property (@(posedge clk_in) state_reg == HCB_ST_WAIT_HOST && host_gate_en_in);
endmodule // hcb_boot_seq

// *** rtl/hcb_pkg.sv ***
// Constants for the host controller boot sequencer and mux signalling block
package hcb_pkg;
    // ========================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int RAIL_SETTLE_US = 100;
    localparam int RAIL_SETTLE_CYC = RAIL_SETTLE_US * CLK_MHZ;
    localparam int CNT_W = 16;
    // ========================================
    // Target address of the secondary I2C target port
    localparam logic [6:0] TARGET_ADDR = 7'h38;
    // ========================================
    // Status byte field positions
    localparam int ST_ATTACH = 0;
    localparam int ST_FLIP = 1;
    localparam int ST_USB3 = 2;
    localparam int ST_DP = 3;
    localparam int ST_HSL = 4;
    localparam int ST_BOOTED = 5;
    // ========================================
    // Sequencer states
    typedef enum logic [2:0] {
        HCB_ST_CFG_LOAD = 3'b000,
        HCB_ST_WAIT_RAIL = 3'b001,
        HCB_ST_SETTLE = 3'b010,
        HCB_ST_WAIT_HOST = 3'b011,
        HCB_ST_RUN = 3'b100
    } hcb_state_e;
endpackage

// *** rtl/hcb_i2c_target.sv ***
// I2C target that answers one 7-bit address and returns a status byte
`timescale 1ns/100ps
module hcb_i2c_target (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [7:0] status_in,
    output logic sda_oe_out,
    output logic read_done_out
);
    import hcb_pkg::*;
    logic [2:0] scl_sync_reg, sda_sync_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg, tx_reg;
    logic active_reg, ack_reg, rd_reg, send_reg, addr_ok_reg, oe_reg, done_reg;
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_sync_reg[2];
    wire scl_fall = ~scl_s & scl_sync_reg[2];
    wire start_c = scl_s & sda_sync_reg[2] & ~sda_s;
    wire stop_c = scl_s & ~sda_sync_reg[2] & sda_s;
    wire addr_hit = (shift_reg[7:1] == TARGET_ADDR);
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            active_reg <= 1'b0;
            ack_reg <= 1'b0;
            rd_reg <= 1'b0;
            send_reg <= 1'b0;
            addr_ok_reg <= 1'b0;
            oe_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce_in) begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            done_reg <= 1'b0;
            if (start_c) begin
                active_reg <= 1'b1;
                addr_ok_reg <= 1'b0;
                send_reg <= 1'b0;
                bit_reg <= 4'h0;
                oe_reg <= 1'b0;
            end else if (stop_c) begin
                active_reg <= 1'b0;
                oe_reg <= 1'b0;
            end else if (active_reg && scl_rise && !ack_reg && !send_reg) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_reg <= bit_reg + 4'h1;
            end else if (active_reg && scl_rise && send_reg && bit_reg == 4'h8) begin
                // SDA high on the clock rise of the eighth data bit ends the read
                if (sda_s) begin
                    send_reg <= 1'b0;
                    active_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
                bit_reg <= 4'h0;
            end else if (active_reg && scl_fall) begin
                if (!send_reg && !ack_reg && bit_reg == 4'h8) begin
                    // Only the first byte is an address; acknowledge a match
                    if (!addr_ok_reg && addr_hit) begin
                        ack_reg <= 1'b1;
                        oe_reg <= 1'b1;
                        addr_ok_reg <= 1'b1;
                        rd_reg <= shift_reg[0];
                    end else if (!addr_ok_reg) begin
                        active_reg <= 1'b0;
                    end else begin
                        ack_reg <= 1'b1;
                        oe_reg <= 1'b1;
                    end
                    bit_reg <= 4'h0;
                end else if (ack_reg) begin
                    ack_reg <= 1'b0;
                    oe_reg <= 1'b0;
                    if (rd_reg) begin
                        send_reg <= 1'b1;
                        tx_reg <= {status_in[6:0], 1'b0};
                        oe_reg <= ~status_in[7];
                        bit_reg <= 4'h1;
                    end
                end else if (send_reg && bit_reg != 4'h8) begin
                    oe_reg <= ~tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b0};
                    bit_reg <= bit_reg + 4'h1;
                end else if (send_reg) begin
                    oe_reg <= 1'b0;
                end
            end
        end
    end
    // Address byte is the shifted value seen before the ack slot
    assign sda_oe_out = oe_reg;
    assign read_done_out = done_reg;
endmodule // hcb_i2c_target

// *** tb/hcb_host_model.sv ***
// Model of the external controller: status reader over I2C and rail-gated reset
`timescale 1ns/100ps
module hcb_host_model (
    input wire logic clk_in,
    input wire logic sda_oe_in,
    input wire logic reset_line_n_in,
    input wire logic rail_in,
    output logic scl_out,
    output logic sda_out,
    output logic ctrl_reset_n_out
);
    localparam int Q = 16;
    logic sda_low_reg;
    // Open-drain bus with pull-up: low when either party pulls
    assign sda_out = ~(sda_low_reg | sda_oe_in);
    // Board gating keeps reset asserted while the rail is absent
    assign ctrl_reset_n_out = reset_line_n_in & rail_in;
    initial begin
        scl_out = 1'b1;
        sda_low_reg = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Data changes only while the clock line is low
    task automatic bit_io(input logic b, output logic s);
        scl_out <= 1'b0;
        wt(Q);
        sda_low_reg <= ~b;
        wt(Q);
        scl_out <= 1'b1;
        wt(Q);
        s = sda_out;
    endtask
    // Read one byte from a 7-bit address, then NACK and stop
    task automatic xfer(input logic [6:0] addr, output logic ack, output logic [7:0] data);
        logic s;
        logic [7:0] frame;
        frame = {addr, 1'b1};
        data = 8'h00;
        @(posedge clk_in);
        sda_low_reg <= 1'b1;
        wt(Q);
        for (int i = 7; i >= 0; i--) begin
            bit_io(frame[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
        if (ack) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(1'b1, s);
                data[i] = s;
            end
            bit_io(1'b1, s);
        end
        scl_out <= 1'b0;
        wt(Q);
        sda_low_reg <= 1'b1;
        wt(Q);
        scl_out <= 1'b1;
        wt(Q);
        sda_low_reg <= 1'b0;
        wt(Q);
    endtask
endmodule // hcb_host_model

// *** tb/hcb_boot_seq_tb_top.sv ***
// Testbench for the controller reset sequencer and mux signalling block
`timescale 1ns/100ps
module hcb_boot_seq_tb_top;
    import hcb_pkg::*;
    logic clk_in, rstn_in, ce_in, cfg_done, rail, gate_en, boot_ok, attach;
    logic orient, usb3, dp, hsl, mode, irq_clear, ack;
    logic rl_n, grant, sa, sb, aux, ls, flip, ul, dl, irq_n, sda_oe, scl, sda, ctl_n;
    logic [7:0] data;
    int n_errors = 0;
    int n_tests = 0;
    int cnt;
    hcb_boot_seq i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .cfg_done_in(cfg_done), .controller_3v3_rail_in(rail), .host_gate_en_in(gate_en),
        .host_boot_ok_in(boot_ok), .attach_in(attach), .orient_in(orient),
        .usb3_evt_in(usb3), .dp_evt_in(dp), .hsl_evt_in(hsl), .gpio_mux_mode_in(mode),
        .irq_clear_in(irq_clear), .scl_in(scl), .sda_in(sda),
        .host_ctrl_reset_line_n_out(rl_n), .flash_grant_out(grant),
        .sideband_pair_select_a_out(sa), .sideband_pair_select_b_out(sb),
        .dp_aux_path_enable_out(aux), .low_speed_path_enable_out(ls), .ss_flip_out(flip),
        .usb3_lane_control_out(ul), .dp_lane_control_out(dl), .host_irq_n_out(irq_n),
        .sda_oe_out(sda_oe));
    hcb_host_model i_host (.clk_in(clk_in), .sda_oe_in(sda_oe), .reset_line_n_in(rl_n),
        .rail_in(rail), .scl_out(scl), .sda_out(sda), .ctrl_reset_n_out(ctl_n));
    always #2.5 clk_in = ~clk_in;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_rl();
        cnt = 0;
        while (rl_n !== 1'b1 && cnt < 25000) begin
            tick(1);
            cnt++;
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_in);
        n_errors++;
        wrap_up();
    end
    initial begin
        clk_in = 0; rstn_in = 0; ce_in = 1; cfg_done = 0; rail = 0; gate_en = 0;
        boot_ok = 0; attach = 0; orient = 0; usb3 = 0; dp = 0; hsl = 0; mode = 0;
        irq_clear = 0;
        tick(6);
        rstn_in <= 1'b1;
        tick(30);
        chk("reset_line", 8'h00, rl_n);
        chk("grant", 8'h00, grant);
        chk("irq_n", 8'h01, irq_n);
        cfg_done <= 1'b1;
        tick(4);
        chk("grant", 8'h01, grant);
        chk("reset_line", 8'h00, rl_n);
        rail <= 1'b1;
        wait_rl();
        chk("settle", 8'h01, cnt >= RAIL_SETTLE_CYC && cnt <= RAIL_SETTLE_CYC + 10);
        // Every event and mode combination, one cycle of latency
        for (int i = 0; i < 32; i++) begin
            {mode, orient, usb3, dp, hsl} <= i[4:0];
            tick(2);
            chk("sideband", {4'h0, i[3], i[3], i[1], i[0]}, {4'h0, sa, sb, aux, ls});
            chk("lanes", {5'h0, i[4] & i[3], i[4] & i[2], i[4] & i[1]},
                {5'h0, flip, ul, dl});
        end
        // Clock enable low freezes the mux outputs
        ce_in <= 1'b0;
        hsl <= 1'b0;
        tick(3);
        chk("freeze", 8'h01, ls);
        ce_in <= 1'b1;
        hsl <= 1'b1;
        attach <= 1'b1;
        dp <= 1'b0;
        tick(6);
        chk("irq_n", 8'h00, irq_n);
        i_host.xfer(7'h39, ack, data);
        chk("ack_other", 8'h00, ack);
        chk("irq_n", 8'h00, irq_n);
        i_host.xfer(7'h38, ack, data);
        chk("ack", 8'h01, ack);
        chk("status", 8'h37, data);
        tick(6);
        chk("irq_n", 8'h01, irq_n);
        attach <= 1'b0;
        tick(6);
        chk("irq_n", 8'h00, irq_n);
        irq_clear <= 1'b1;
        tick(1);
        irq_clear <= 1'b0;
        tick(5);
        chk("irq_n", 8'h01, irq_n);
        i_host.xfer(7'h38, ack, data);
        chk("status", 8'h20, data);
        rail <= 1'b0;
        tick(8);
        chk("reset_line", 8'h00, rl_n);
        chk("gated_reset", 8'h00, ctl_n);
        chk("grant", 8'h01, grant);
        gate_en <= 1'b1;
        rail <= 1'b1;
        wait_rl();
        chk("reset_line", 8'h00, rl_n);
        boot_ok <= 1'b1;
        tick(4);
        chk("reset_line", 8'h01, rl_n);
        chk("gated_reset", 8'h01, ctl_n);
        wrap_up();
    end
endmodule // hcb_boot_seq_tb_top
